/* emwc_waitgen.sv */
// package and per-bus wait-state sequencer for the mapper wait control
package emwc_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [3:0]  CFG_OFS        = 4'h0;
   localparam logic [3:0]  MAP_OFS        = 4'h4;
   localparam logic [3:0]  STAT_OFS       = 4'h8;
   // cfg field positions
   localparam int          CFG_FAST_POS   = 0;
   localparam int          CFG_EMEM_POS   = 1;
   localparam int          CFG_CLK2_POS   = 2;
   localparam int          CFG_BMIN_POS   = 4;
   localparam int          CFG_SMIN_POS   = 8;
   // reset values and legal ranges
   localparam logic [3:0]  BMIN_RST       = 4'h1;
   localparam logic [3:0]  BMIN_MAX       = 4'h4;
   localparam logic [3:0]  SMIN_RST       = 4'h2;
   localparam logic [3:0]  SMIN_MAX       = 4'h9;
   localparam logic [31:0] MAP_RST        = 32'h0000_0000;
   // clock class boundary, informational: software picks the class
   localparam int          FAST_CLASS_MHZ = 25;
   // translation wait states at fast class
   localparam logic [3:0]  XLAT_WS        = 4'h1;
   // region kinds in the map, two bits per 256 MiB region
   localparam logic [1:0]  KIND_TARGET    = 2'h0;
   localparam logic [1:0]  KIND_RAM       = 2'h1;
   localparam logic [1:0]  KIND_ROM       = 2'h2;
   localparam logic [1:0]  KIND_GUARD     = 2'h3;

   typedef struct packed {
      logic        req_n;
      logic        burst;
      logic        write;
      logic [31:0] addr;
   } emwc_busreq_t;

   typedef enum logic [1:0] {
      WG_IDLE = 2'b00,
      WG_WAIT = 2'b01,
      WG_PASS = 2'b11
   } emwc_wg_state_t;
endpackage

// -------------------------------------------------------------------
// wait sequencer: hold ready inactive for ws cycles, then pass source
// -------------------------------------------------------------------
module emwc_waitgen #(
   parameter int WSW = 4
) (
   input  wire logic           core_clk,
   input  wire logic           arst_n,
   input  wire logic           start,
   input  wire logic [WSW-1:0] ws,
   input  wire logic           src_ready,
   output logic                taken,
   output logic                ready,
   output logic                busy
);
   import emwc_pkg::*;

   emwc_wg_state_t state_ff;
   logic [WSW-1:0] cnt_ff;

   if (WSW < 4) begin : g_wsw_chk
      $error("wait counter too narrow");
   end

   assign taken = start && (state_ff == WG_IDLE);
   assign ready = (state_ff == WG_PASS) && src_ready;
   assign busy  = (state_ff != WG_IDLE);

   // (R14) one inactive ready per wait state
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= WG_IDLE;
         cnt_ff   <= '0;
      end else begin
         case (state_ff)
            WG_IDLE: begin
               if (taken) begin
                  state_ff <= (ws == '0) ? WG_PASS : WG_WAIT;
                  cnt_ff   <= ws;
               end
            end
            WG_WAIT: begin
               cnt_ff <= cnt_ff - 1'b1;
               if (cnt_ff == {{(WSW-1){1'b0}}, 1'b1}) state_ff <= WG_PASS;
            end
            WG_PASS: begin
               if (src_ready) state_ff <= WG_IDLE;
            end
            default: state_ff <= WG_IDLE;
         endcase
      end
   end
endmodule

/* emwc_top.sv */
// mapper wait-state and request gating between processor, target and emulation memory
// How it works
// (R1) normal class: no translation wait
// (R2) fast class with mapper: one translation wait
// (R3) mapper off: clock class ignored
// (R4) mapper off: no waits, all to target
// (R5) mapper off: no memory-type breaks
// (R6) fast mapper: new request gets dead cycle
// (R7) dead cycle only on first access
// (R8) target adds a wait on first access
// (R9) mapper on blocks pipeline enable
// (R10) enabling mapper loads latest host map
// (R11) extra waits from configured minimums
// (R12) clocks per emulation access: one or two
// (R13) pad natural waits up to minimum
// (R14) each wait holds ready inactive
module emwc_top (
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire emwc_pkg::emwc_busreq_t instruction_request,
   input  wire emwc_pkg::emwc_busreq_t data_request,
   input  wire logic [1:0]            tgt_ready_n,
   input  wire logic                  tgt_pipeline_enable_n,
   output logic [1:0]                 proc_ready_n,
   output logic                       proc_pipeline_enable_n,
   output logic [1:0]                 route_emem,
   output logic                       guard_break,
   output logic                       rom_write_break
);
   import emwc_pkg::*;

   // ---------------------------------------------------------------
   // configuration and map registers
   // ---------------------------------------------------------------
   logic        fast_ff;
   logic        emem_ff;
   logic        clk2_ff;
   logic [3:0]  bmin_ff;
   logic [3:0]  smin_ff;
   logic [31:0] map_ff;
   logic [31:0] act_map_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic        wr_go;
   logic        cfg_wr;
   logic [3:0]  nxt_bmin;
   logic [3:0]  nxt_smin;
   logic [1:0]  busy_w;

   // answer one cycle after the request is seen
   assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
   assign wr_go           = avs_write && ack_ff;
   assign cfg_wr          = wr_go && (avs_address == CFG_OFS) && avs_byteenable[0]
                            && avs_byteenable[1];
   assign avs_readdata    = rdata_ff;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) ack_ff <= 1'b0;
      else         ack_ff <= (avs_read || avs_write) && !ack_ff;
   end

   // out-of-range minimums are clamped so emulation accesses never get a zero minimum
   always_comb begin
      nxt_bmin = avs_writedata[CFG_BMIN_POS +: 4];
      nxt_smin = avs_writedata[CFG_SMIN_POS +: 4];
      if (nxt_bmin < BMIN_RST) nxt_bmin = BMIN_RST;
      if (nxt_bmin > BMIN_MAX) nxt_bmin = BMIN_MAX;
      if (nxt_smin < SMIN_RST) nxt_smin = SMIN_RST;
      if (nxt_smin > SMIN_MAX) nxt_smin = SMIN_MAX;
   end

   // (R12) single bit selects one or two clocks
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fast_ff <= 1'b0;
         emem_ff <= 1'b0;
         clk2_ff <= 1'b0;
         bmin_ff <= BMIN_RST;
         smin_ff <= SMIN_RST;
      end else if (cfg_wr) begin
         fast_ff <= avs_writedata[CFG_FAST_POS];
         emem_ff <= avs_writedata[CFG_EMEM_POS];
         clk2_ff <= avs_writedata[CFG_CLK2_POS];
         bmin_ff <= nxt_bmin;
         smin_ff <= nxt_smin;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         map_ff <= MAP_RST;
      end else if (wr_go && (avs_address == MAP_OFS)) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) map_ff[8*b +: 8] <= avs_writedata[8*b +: 8];
         end
      end
   end

   // (R10) the map in use is snapped when the mapper turns on
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) act_map_ff <= MAP_RST;
      else if (cfg_wr && !emem_ff && avs_writedata[CFG_EMEM_POS]) act_map_ff <= map_ff;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read && !ack_ff) begin
         case (avs_address)
            CFG_OFS:  rdata_ff <= {20'h0_0000, smin_ff, bmin_ff, 1'b0, clk2_ff,
                                   emem_ff, fast_ff};
            MAP_OFS:  rdata_ff <= map_ff;
            STAT_OFS: rdata_ff <= {29'h0000_0000, busy_w, emem_ff};
            default:  rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // per-bus wait computation
   // ---------------------------------------------------------------
   emwc_busreq_t   bus_w [2];
   logic [3:0]     ws_w [2];
   logic [1:0]     kind_w [2];
   logic [1:0]     first_w;
   logic [1:0]     to_emem_w;
   logic [1:0]     taken_w;
   logic [1:0]     ready_w;
   logic [1:0]     guard_w;
   logic [1:0]     romwr_w;

   assign bus_w[0] = instruction_request;
   assign bus_w[1] = data_request;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_bus
         logic [3:0] xlat;
         logic [3:0] natural_ws;
         logic [3:0] min_ws;

         assign kind_w[i]     = act_map_ff[2*bus_w[i].addr[31:28] +: 2];
         assign first_w[i]    = !bus_w[i].burst;
         // (R4) mapper off sends every access to the target
         assign to_emem_w[i]  = emem_ff && ((kind_w[i] == KIND_RAM) || (kind_w[i] == KIND_ROM));
         assign route_emem[i] = to_emem_w[i];
         // (R1) (R2) translation wait only at fast class with mapper
         // (R3) (R6) (R7) gated by mapper and by first access
         assign xlat       = (emem_ff && fast_ff && first_w[i]) ? XLAT_WS : 4'h0;
         assign natural_ws = xlat + (to_emem_w[i] ? (clk2_ff ? 4'h2 : 4'h1) : 4'h0);
         assign min_ws     = to_emem_w[i] ? (first_w[i] ? smin_ff : bmin_ff) : 4'h0;
         // (R11) (R13) pad short accesses up to the minimum
         assign ws_w[i]    = (natural_ws < min_ws) ? min_ws : natural_ws;
         // (R5) memory-type breaks need the mapper
         assign guard_w[i] = taken_w[i] && emem_ff && (kind_w[i] == KIND_GUARD);
         assign romwr_w[i] = taken_w[i] && emem_ff && (kind_w[i] == KIND_ROM)
                             && bus_w[i].write;
         assign proc_ready_n[i] = !ready_w[i];

         // (R8) target ready is trusted once the ws_w waits have passed
         emwc_waitgen #(
            .WSW       (4)
         ) u_wait (
            .core_clk  (core_clk),
            .arst_n    (arst_n),
            .start     (!bus_w[i].req_n || bus_w[i].burst),
            .ws        (ws_w[i]),
            .src_ready (to_emem_w[i] || !tgt_ready_n[i]),
            .taken     (taken_w[i]),
            .ready     (ready_w[i]),
            .busy      (busy_w[i])
         );

         sequence s_dead;
            proc_ready_n[i] ##1 proc_ready_n[i];
         endsequence

         a_normal_nowait: assert property (@(posedge core_clk) disable iff (!arst_n) // (R1)
            taken_w[i] && emem_ff && !fast_ff && !to_emem_w[i] |-> ws_w[i] == 4'h0)
            else $error("normal class added a translation wait");
         a_fast_onewait: assert property (@(posedge core_clk) disable iff (!arst_n) // (R2)
            taken_w[i] && emem_ff && fast_ff && first_w[i] && !to_emem_w[i]
            |-> ws_w[i] == 4'h1)
            else $error("fast class target access lacks one wait");
         a_class_ignored: assert property (@(posedge core_clk) disable iff (!arst_n) // (R3)
            taken_w[i] && !emem_ff |-> ws_w[i] == 4'h0)
            else $error("clock class affected timing with mapper off");
         a_route_target: assert property (@(posedge core_clk) disable iff (!arst_n) // (R4)
            !emem_ff |-> !route_emem[i])
            else $error("access routed to emulation memory with mapper off");
         a_dead_cycle: assert property (@(posedge core_clk) disable iff (!arst_n) // (R6)
            taken_w[i] && ws_w[i] == 4'h1 |-> s_dead ##1 (proc_ready_n[i] == (!to_emem_w[i]
            && tgt_ready_n[i])))
            else $error("dead cycle not one clock long");
         a_burst_nowait: assert property (@(posedge core_clk) disable iff (!arst_n) // (R7)
            taken_w[i] && !first_w[i] && !to_emem_w[i]
            |=> proc_ready_n[i] == tgt_ready_n[i])
            else $error("burst target beat was delayed");
         a_pad_minimum: assert property (@(posedge core_clk) disable iff (!arst_n) // (R13)
            taken_w[i] && to_emem_w[i] && first_w[i] |-> ws_w[i] >= smin_ff)
            else $error("emulation access below minimum waits");

         // (R14) cycles of inactive ready since the access was taken
         // only emulation accesses are judged: a slow target stretches the count
         logic [3:0] held_ff;
         logic [3:0] ws_hold_ff;

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               held_ff    <= 4'h0;
               ws_hold_ff <= 4'h0;
            end else if (taken_w[i]) begin
               held_ff    <= 4'h0;
               ws_hold_ff <= ws_w[i];
            end else if (busy_w[i] && proc_ready_n[i]) begin
               held_ff <= held_ff + 4'h1;
            end
         end

         sequence s_fast_start;
            taken_w[i] && emem_ff && fast_ff && first_w[i];
         endsequence

         a_wait_count: assert property (@(posedge core_clk) disable iff (!arst_n) // (R14)
            busy_w[i] && !proc_ready_n[i] && to_emem_w[i] |-> held_ff == ws_hold_ff)
            else $error("emulation access waits differ from computed count");
         a_wait_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // (R14)
            taken_w[i] && ws_w[i] != 4'h0 |=> proc_ready_n[i])
            else $error("ready active during a wait state");
         // a ready held too long would let the processor finish a second beat unseen
         a_ready_once: assert property (@(posedge core_clk) disable iff (!arst_n) // (R14)
            !proc_ready_n[i] |=> proc_ready_n[i])
            else $error("ready held active for more than one cycle");
         a_fast_dead: assert property (@(posedge core_clk) disable iff (!arst_n) // (R6)
            s_fast_start |=> proc_ready_n[i])
            else $error("fast class access missed its dead cycle");
         a_emem_xlat: assert property (@(posedge core_clk) disable iff (!arst_n) // (R2)
            taken_w[i] && emem_ff && fast_ff && first_w[i] && to_emem_w[i] |-> ws_w[i] >= 4'h2)
            else $error("fast class emulation access lacks translation wait");
         a_burst_min: assert property (@(posedge core_clk) disable iff (!arst_n) // (R7)
            taken_w[i] && !first_w[i] && to_emem_w[i] && !clk2_ff |-> ws_w[i] == bmin_ff)
            else $error("burst emulation beat carried a translation wait");
      end
   endgenerate

   // ---------------------------------------------------------------
   // breaks and pipeline enable
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         guard_break     <= 1'b0;
         rom_write_break <= 1'b0;
      end else begin
         guard_break     <= |guard_w;
         rom_write_break <= |romwr_w;
      end
   end

   // (R9) pipelining only without the mapper in the path
   assign proc_pipeline_enable_n = emem_ff ? 1'b1 : tgt_pipeline_enable_n;

   a_no_typebreak: assert property (@(posedge core_clk) disable iff (!arst_n) // (R5)
      !$past(emem_ff) |-> !guard_break && !rom_write_break)
      else $error("memory-type break with mapper off");
   a_pen_blocked: assert property (@(posedge core_clk) disable iff (!arst_n) // (R9)
      emem_ff |-> proc_pipeline_enable_n)
      else $error("pipeline enable reached processor with mapper on");
   a_map_snap: assert property (@(posedge core_clk) disable iff (!arst_n) // (R10)
      $rose(emem_ff) |-> act_map_ff == $past(map_ff))
      else $error("map in use is not the latest loaded");
   a_bus_answer: assert property (@(posedge core_clk) disable iff (!arst_n)
      (avs_read || avs_write) && !ack_ff |=> !avs_waitrequest)
      else $error("bus answer later than one cycle");

   // ---------------------------------------------------------------
   // configuration checks
   // ---------------------------------------------------------------
   // clamped minimums keep emulation accesses from ever seeing a zero floor
   a_pen_pass: assert property (@(posedge core_clk) disable iff (!arst_n) // (R9)
      !emem_ff |-> proc_pipeline_enable_n == tgt_pipeline_enable_n)
      else $error("pipeline enable blocked with mapper off");
   a_map_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // (R10)
      !$rose(emem_ff) |-> $stable(act_map_ff))
      else $error("map in use changed without enabling the mapper");
   a_bmin_range: assert property (@(posedge core_clk) disable iff (!arst_n) // (R11)
      bmin_ff >= BMIN_RST && bmin_ff <= BMIN_MAX)
      else $error("burst minimum outside its range");
   a_smin_range: assert property (@(posedge core_clk) disable iff (!arst_n) // (R11)
      smin_ff >= SMIN_RST && smin_ff <= SMIN_MAX)
      else $error("simple minimum outside its range");
endmodule

/* emwc_tgt_mem.sv */
// target memory model: per-bus ready after a set latency
module emwc_tgt_mem
   import emwc_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   input  wire emwc_busreq_t instruction_request,
   input  wire emwc_busreq_t data_request,
   input  wire logic [3:0]   dly,
   output logic [1:0]        tgt_ready_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] act;
   logic [3:0] cnt_ff [2];
   assign act = {!data_request.req_n | data_request.burst,
                 !instruction_request.req_n | instruction_request.burst};
   // -----------------------------------------------------------
   // latency per access
   // -----------------------------------------------------------
   // wait on an access that follows an idle cycle, first or burst, and again each time the count wraps
   // count restarts when the request drops and wraps after 16 active cycles, so dly of one or more costs a wait after each idle cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      for (int b = 0; b < 2; b++) begin
         if (!arst_n) cnt_ff[b] <= 4'h0;
         else cnt_ff[b] <= act[b] ? cnt_ff[b] + 4'h1 : 4'h0;
      end
   end
   // not ready reads high, never the last value
   assign tgt_ready_n = {!(act[1] && cnt_ff[1] >= dly), !(act[0] && cnt_ff[0] >= dly)};
endmodule

/* test_emwc_top.sv */
// self-checking bench for the mapper wait control
module test_emwc_top;
   timeunit 1ns;
   timeprecision 1ns;
   import emwc_pkg::*;
   localparam emwc_busreq_t IDLE_REQ = '{1'b1, 1'b0, 1'b0, 32'h0};
   logic         core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
   logic         pipe_in_n, proc_pipeline_enable_n, guard_break, rom_write_break;
   logic [3:0]   avs_address, dly, bmin, smin;
   logic [31:0]  avs_writedata, avs_readdata, cfg, mapw, amap;
   logic [1:0]   tgt_ready_n, proc_ready_n, route_emem;
   emwc_busreq_t instr_req, data_req;
   logic [7:0]   q [$];
   logic [7:0]   e_m;
   logic         b_m;
   int           bad_count, tests_run, cnt_m;

   emwc_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .instruction_request(instr_req), .data_request(data_req), .tgt_ready_n(tgt_ready_n),
      .tgt_pipeline_enable_n(pipe_in_n), .proc_ready_n(proc_ready_n),
      .proc_pipeline_enable_n(proc_pipeline_enable_n), .route_emem(route_emem),
      .guard_break(guard_break), .rom_write_break(rom_write_break));
   emwc_tgt_mem tgt_u (.core_clk(core_clk), .arst_n(arst_n), .instruction_request(instr_req),
      .data_request(data_req), .dly(dly), .tgt_ready_n(tgt_ready_n));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // -----------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------
   task automatic end_sim;
      $display("tests run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is seen low, then released
   task automatic reg_acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] x);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      x = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 20) begin bad_count++; end_sim(); end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] x;
      reg_acc(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      reg_acc(1'b1, a, d, x);
      if (a == MAP_OFS) mapw = d;
      if (a == CFG_OFS) begin
         if (d[CFG_EMEM_POS] && !cfg[CFG_EMEM_POS]) amap = mapw;
         cfg = d;
         bmin = d[7:4] < 4'h1 ? 4'h1 : d[7:4] > BMIN_MAX ? BMIN_MAX : d[7:4];
         smin = d[11:8] < 4'h2 ? 4'h2 : d[11:8] > SMIN_MAX ? SMIN_MAX : d[11:8];
      end
   endtask
   task automatic acc(input logic b, input logic bu, input logic w, input logic [3:0] rg);
      emwc_busreq_t r;
      logic [1:0]   k;
      logic         em, pin, on;
      int           ws, mn, lat, n;
      on = cfg[CFG_EMEM_POS];
      k = on ? amap[2*rg +: 2] : KIND_TARGET;
      em = on && (k == KIND_RAM || k == KIND_ROM);
      ws = (on && cfg[CFG_FAST_POS] && !bu) + (em ? 1 + cfg[CFG_CLK2_POS] : 0);
      mn = !em ? 0 : bu ? bmin : smin;
      if (mn > ws) ws = mn;
      r = '{req_n: bu, burst: bu, write: w, addr: {rg, 28'($urandom)}};
      pin = 1'($urandom);
      @(posedge core_clk);
      // latency taken here so a dly update from an earlier step has landed
      lat = (em || 1 + ws > dly) ? 1 + ws : dly;
      q.push_back({k == KIND_GUARD, em, 6'(lat)});
      pipe_in_n <= pin;
      if (b) data_req <= r;
      else instr_req <= r;
      @(posedge core_clk);
      @(negedge core_clk);
      chk(proc_pipeline_enable_n, on | pin);
      chk(guard_break, on && k == KIND_GUARD);
      chk(rom_write_break, on && k == KIND_ROM && w);
      for (n = 0; n < 40 && proc_ready_n[b] !== 1'b0; n++) @(negedge core_clk);
      if (n == 40) begin bad_count++; end_sim(); end
      @(posedge core_clk);
      if (b) data_req <= IDLE_REQ;
      else instr_req <= IDLE_REQ;
      @(posedge core_clk);
   endtask
   // both buses, first and burst, four regions
   task automatic sweep;
      for (int i = 0; i < 16; i++) acc(i[0], i[1], 1'($urandom), 4'(i >> 2));
   endtask
   // -----------------------------------------------------------
   // result watcher
   // -----------------------------------------------------------
   always @(negedge core_clk) begin
      if (!instr_req.req_n || instr_req.burst || !data_req.req_n || data_req.burst) cnt_m++;
      if (arst_n && proc_ready_n !== 2'b11) begin
         b_m = !proc_ready_n[1];
         e_m = q.size() ? q.pop_front() : 8'hff;
         chk(32'(cnt_m), 32'(e_m[5:0]) + 32'h1);
         if (!e_m[7]) chk(32'(route_emem[b_m]), 32'(e_m[6]));
         cnt_m = 0;
      end
   end
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      instr_req = IDLE_REQ;
      data_req = IDLE_REQ;
      pipe_in_n = 1'b1;
      dly = 4'h1;
      {bad_count, tests_run, cnt_m} = '0;
      {cfg, bmin, smin, mapw, amap} = {32'h210, 4'h1, 4'h2, 64'h0};
      void'($urandom(32'hb0b3));
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(CFG_OFS, 32'h0000_0210);
      rd(MAP_OFS, MAP_RST);
      rd(STAT_OFS, 32'h0);
      rd(4'hc, 32'h0);
      $display("test reset values done");
      wr(MAP_OFS, 32'h0000_00e4);
      wr(CFG_OFS, 32'h0000_0212);
      rd(STAT_OFS, 32'h1);
      sweep();
      $display("test normal class mapper done");
      for (int c = 0; c < 6; c++) begin
         wr(CFG_OFS, {20'h0, 4'($urandom), 4'($urandom), 1'b0, c[1], 1'b1, c[0]});
         dly <= 4'h1 + 4'($urandom % 4);
         sweep();
      end
      $display("test class and minimum sweep done");
      wr(MAP_OFS, 32'h0000_0039);
      sweep();
      wr(CFG_OFS, 32'h0000_0211);
      rd(STAT_OFS, 32'h0);
      sweep();
      $display("test mapper off done");
      wr(CFG_OFS, 32'h0000_0213);
      sweep();
      $display("test map reload done");
      end_sim();
   end
endmodule
